// ### core/timebase_defines.svh
`ifndef TIMEBASE_DEFINES_SVH
`define TIMEBASE_DEFINES_SVH
// register indices; byte address is four times the index
`define CSR_INDEX      8'h26
`define IRQ_STAT_INDEX 8'h27
`define IRQ_MASK_INDEX 8'h28
`define CSR_RESET      8'h00
`define IRQ_RESET      1'b0
`define FLAG_BIT       0
`define IEN_BIT        1
`define SEL_LSB        2
`define SEL_MSB        3
// divide ratios in half-rate oscillator cycles
`define DIV_SEL0       18'd16000
`define DIV_SEL1       18'd32000
`define DIV_SEL2       18'd80000
`define DIV_SEL3       18'd200000
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// ### core/timebase_pkg.sv
package timebase_pkg;
  typedef enum logic [1:0] {
    MODE_RUN  = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_HOLD = 2'b10,
    MODE_HALT = 2'b11
  } power_mode_t;
  typedef logic [1:0] period_sel_t;
endpackage

// ### core/periodic_timebase_tick.sv
`timescale 1ns/100ps
`include "timebase_defines.svh"
// Functional notes
// - divider counts oscillator edges, ratio 16000/32000/80000/200000 by period select
// - new period select takes effect only at the next period boundary
// - period end sets the tick flag in bit 0
// - reading the control/status register clears the tick flag
// - tick request only with flag, enable bit 1 and cpu mask clear
// - halt with tick enable set enters active hold instead of halt
// - wait mode keeps counting; tick request leaves wait
// - active hold keeps counting, control/status register frozen to bus access, tick request ends it
// - full halt freezes counter and register until a halt wake source
// - tick wakes from wait and active hold, never from full halt
// - reset clears the register; bits 7 to 4 read zero
// - period select and enable are software read/write fields
module periodic_timebase_tick (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic                      half_rate_osc_clock,
  input  wire logic                      global_irq_mask,
  input  wire logic                      wait_enter,
  input  wire logic                      halt_exec,
  input  wire logic                      ext_wake,
  output logic                           tick_irq_req,
  output logic                           irq,
  output timebase_pkg::power_mode_t      power_mode
);
  import timebase_pkg::*;

  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] index);
    is_reg = (addr == {index[5:0], 2'b00});
  endfunction

  function automatic logic [17:0] period_last(input period_sel_t sel);
    case (sel)
      2'b00:   period_last = `DIV_SEL0 - 18'd1;
      2'b01:   period_last = `DIV_SEL1 - 18'd1;
      2'b10:   period_last = `DIV_SEL2 - 18'd1;
      default: period_last = `DIV_SEL3 - 18'd1;
    endcase
  endfunction

  // bus and register state
  logic        aw_held;
  logic [7:0]  aw_addr_q;
  logic        w_held;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        tick_flag;
  logic        tick_irq_enable;
  period_sel_t period_select;
  logic        irq_status;
  logic        irq_mask;
  logic        next_aw_held;
  logic [7:0]  next_aw_addr_q;
  logic        next_w_held;
  logic [31:0] next_wdata_q;
  logic [3:0]  next_wstrb_q;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;
  logic        next_tick_flag;
  logic        next_tick_irq_enable;
  period_sel_t next_period_select;
  logic        next_irq_status;
  logic        next_irq_mask;

  // divider and mode state
  logic        osc_sync1;
  logic        osc_sync2;
  logic        osc_prev;
  logic [17:0] div_count;
  period_sel_t active_sel;
  logic        tick;
  power_mode_t next_power_mode;
  logic [17:0] next_div_count;
  period_sel_t next_active_sel;
  logic        next_tick;

  logic        frozen;
  logic        do_write;
  logic        ar_hs;
  logic        count_en;
  logic [7:0]  csr_value;

  assign frozen    = (power_mode == MODE_HOLD) || (power_mode == MODE_HALT);
  assign awready   = !aw_held && !bvalid;
  assign wready    = !w_held && !bvalid;
  assign arready   = !rvalid;
  assign do_write  = aw_held && w_held && !bvalid;
  assign ar_hs     = arvalid && arready;
  assign csr_value = {4'h0, period_select, tick_irq_enable, tick_flag};
  assign tick_irq_req = tick_flag && tick_irq_enable && !global_irq_mask;
  assign irq       = irq_status && irq_mask;

  always_comb begin
    next_aw_held         = aw_held;
    next_aw_addr_q       = aw_addr_q;
    next_w_held          = w_held;
    next_wdata_q         = wdata_q;
    next_wstrb_q         = wstrb_q;
    next_bvalid          = bvalid;
    next_bresp           = bresp;
    next_rvalid          = rvalid;
    next_rresp           = rresp;
    next_rdata           = rdata;
    next_tick_flag       = tick_flag;
    next_tick_irq_enable = tick_irq_enable;
    next_period_select   = period_select;
    next_irq_status      = irq_status;
    next_irq_mask        = irq_mask;
    if (awvalid && awready) begin
      next_aw_held   = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held  = 1'b1;
      next_wdata_q = wdata;
      next_wstrb_q = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      // the control/status register ignores writes while the core is stopped
      if (is_reg(aw_addr_q, `CSR_INDEX)) begin
        if (wstrb_q[0] && !frozen) begin
          next_tick_irq_enable = wdata_q[`IEN_BIT];
          next_period_select   = wdata_q[`SEL_MSB:`SEL_LSB];
        end
      end else if (is_reg(aw_addr_q, `IRQ_STAT_INDEX)) begin
        if (wstrb_q[0] && wdata_q[0]) begin
          next_irq_status = 1'b0;
        end
      end else if (is_reg(aw_addr_q, `IRQ_MASK_INDEX)) begin
        if (wstrb_q[0]) begin
          next_irq_mask = wdata_q[0];
        end
      end else begin
        next_bresp = `RESP_SLVERR;
      end
    end
    if (ar_hs) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (is_reg(araddr, `CSR_INDEX)) begin
        next_rdata = {24'h00_0000, csr_value};
        // the flag is lost to any read outside hold and halt, so bit instructions must not touch it
        if (!frozen) begin
          next_tick_flag = 1'b0;
        end
      end else if (is_reg(araddr, `IRQ_STAT_INDEX)) begin
        next_rdata = {31'h0000_0000, irq_status};
      end else if (is_reg(araddr, `IRQ_MASK_INDEX)) begin
        next_rdata = {31'h0000_0000, irq_mask};
      end else begin
        next_rresp = `RESP_SLVERR;
      end
    end
    // hardware set after the read clear, so it wins
    if (tick) begin
      next_tick_flag  = 1'b1;
      next_irq_status = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held         <= 1'b0;
      aw_addr_q       <= 8'h00;
      w_held          <= 1'b0;
      wdata_q         <= 32'h0000_0000;
      wstrb_q         <= 4'h0;
      bvalid          <= 1'b0;
      bresp           <= `RESP_OKAY;
      rvalid          <= 1'b0;
      rresp           <= `RESP_OKAY;
      rdata           <= 32'h0000_0000;
      tick_flag       <= 1'(`CSR_RESET >> `FLAG_BIT);
      tick_irq_enable <= 1'(`CSR_RESET >> `IEN_BIT);
      period_select   <= period_sel_t'(`CSR_RESET >> `SEL_LSB);
      irq_status      <= `IRQ_RESET;
      irq_mask        <= `IRQ_RESET;
    end else begin
      aw_held         <= next_aw_held;
      aw_addr_q       <= next_aw_addr_q;
      w_held          <= next_w_held;
      wdata_q         <= next_wdata_q;
      wstrb_q         <= next_wstrb_q;
      bvalid          <= next_bvalid;
      bresp           <= next_bresp;
      rvalid          <= next_rvalid;
      rresp           <= next_rresp;
      rdata           <= next_rdata;
      tick_flag       <= next_tick_flag;
      tick_irq_enable <= next_tick_irq_enable;
      period_select   <= next_period_select;
      irq_status      <= next_irq_status;
      irq_mask        <= next_irq_mask;
    end
  end

  // the oscillator is asynchronous: count rising edges after the synchroniser
  assign count_en = osc_sync2 && !osc_prev && (power_mode != MODE_HALT);

  always_comb begin
    next_div_count  = div_count;
    next_active_sel = active_sel;
    next_tick       = 1'b0;
    next_power_mode = power_mode;
    if (count_en) begin
      if (div_count >= period_last(active_sel)) begin
        next_div_count  = 18'd0;
        next_active_sel = period_select;
        next_tick       = 1'b1;
      end else begin
        next_div_count = div_count + 18'd1;
      end
    end
    case (power_mode)
      MODE_RUN: begin
        if (halt_exec) begin
          next_power_mode = tick_irq_enable ? MODE_HOLD : MODE_HALT;
        end else if (wait_enter) begin
          next_power_mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (tick_irq_req || ext_wake) begin
          next_power_mode = MODE_RUN;
        end
      end
      MODE_HOLD: begin
        if (tick_irq_req || ext_wake) begin
          next_power_mode = MODE_RUN;
        end
      end
      MODE_HALT: begin
        if (ext_wake) begin
          next_power_mode = MODE_RUN;
        end
      end
      default: begin
        next_power_mode = MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_sync1  <= 1'b0;
      osc_sync2  <= 1'b0;
      osc_prev   <= 1'b0;
      div_count  <= 18'd0;
      active_sel <= period_sel_t'(`CSR_RESET >> `SEL_LSB);
      tick       <= 1'b0;
      power_mode <= MODE_RUN;
    end else begin
      osc_sync1  <= half_rate_osc_clock;
      osc_sync2  <= osc_sync1;
      osc_prev   <= osc_sync2;
      div_count  <= next_div_count;
      active_sel <= next_active_sel;
      tick       <= next_tick;
      power_mode <= next_power_mode;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_count_in_range: assert property (
    div_count <= period_last(active_sel))
    else $error("divider count beyond selected period");
  a_wrap_to_zero: assert property (
    count_en && div_count == period_last(active_sel) |=> tick && div_count == 18'd0)
    else $error("divider did not wrap at period end");
  a_period_kept: assert property (
    !(count_en && div_count == period_last(active_sel)) |=> $stable(active_sel))
    else $error("period changed inside a period");
  a_tick_sets_flag: assert property (
    tick |=> tick_flag && irq_status)
    else $error("tick did not set the flag");
  a_read_clears: assert property (
    ar_hs && is_reg(araddr, `CSR_INDEX) && !frozen && !tick |=> !tick_flag && rvalid)
    else $error("status read did not clear the flag");
  a_hold_entry: assert property (
    power_mode == MODE_RUN && halt_exec && tick_irq_enable |=> power_mode == MODE_HOLD)
    else $error("halt with enable did not enter hold");
  a_wait_exit: assert property (
    power_mode == MODE_WAIT && tick_irq_req |=> power_mode == MODE_RUN)
    else $error("tick request did not leave wait");
  a_hold_exit: assert property (
    power_mode == MODE_HOLD && tick_irq_req |=> power_mode == MODE_RUN)
    else $error("tick request did not end hold");
  a_halt_frozen: assert property (
    power_mode == MODE_HALT |=> $stable(div_count) && $stable(period_select))
    else $error("counter or register moved in halt");
  a_halt_no_tick: assert property (
    power_mode == MODE_HALT && !ext_wake |=> power_mode == MODE_HALT && !tick)
    else $error("halt left without a halt wake source");
  a_sw_fields: assert property (
    do_write && is_reg(aw_addr_q, `CSR_INDEX) && wstrb_q[0] && !frozen
      |=> period_select == $past(wdata_q[3:2]) && bvalid)
    else $error("period select not written");
  a_set_wins: assert property (
    tick && ar_hs |=> tick_flag)
    else $error("tick lost to a coinciding read");
  a_req_gating: assert property (
    tick_irq_req |-> tick_flag && tick_irq_enable && !global_irq_mask)
    else $error("tick request without its conditions");
endmodule

// ### test/test_periodic_timebase_tick.sv
`timescale 1ns/100ps
`include "timebase_defines.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", what, exp, got); end end
module test_periodic_timebase_tick;
  import timebase_pkg::*;
  localparam logic [7:0] A_CSR  = 8'(`CSR_INDEX * 4);
  localparam logic [7:0] A_STAT = 8'(`IRQ_STAT_INDEX * 4);
  localparam logic [7:0] A_MASK = 8'(`IRQ_MASK_INDEX * 4);
  logic        core_clk = 1'b0, rst_b = 1'b0, half_rate_osc_clock = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        global_irq_mask = 1'b0, wait_enter = 1'b0, halt_exec = 1'b0, ext_wake = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, tick_irq_req, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  power_mode_t power_mode;
  logic        osc_on = 1'b0, osc_ph = 1'b0;
  int          osc_edges = 0, num_errors = 0, total_checks = 0, seed = 41440;

  periodic_timebase_tick dut (
    .core_clk(core_clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .half_rate_osc_clock(half_rate_osc_clock), .global_irq_mask(global_irq_mask),
    .wait_enter(wait_enter), .halt_exec(halt_exec), .ext_wake(ext_wake),
    .tick_irq_req(tick_irq_req), .irq(irq), .power_mode(power_mode));

  always #10 core_clk = ~core_clk;

  // oscillator toggles every second core cycle, safely below the synchroniser limit
  always @(posedge core_clk) begin
    if (osc_on) begin
      osc_ph <= ~osc_ph;
      if (osc_ph) begin
        half_rate_osc_clock <= ~half_rate_osc_clock;
        if (!half_rate_osc_clock) osc_edges <= osc_edges + 1;
      end
    end
  end

  // 16000/32000/80000/200000 oscillator edges
  function automatic int ratio(input logic [1:0] s);
    case (s)
      2'b00: return 32'h3e80;
      2'b01: return 32'h7d00;
      2'b10: return 32'h13880;
      default: return 32'h30d40;
    endcase
  endfunction

  function automatic logic [31:0] csr_exp(input logic f, input logic e, input logic [1:0] s);
    return {28'h0, s, e, f};
  endfunction

  function automatic power_mode_t mode_exp(input int k);
    return (k == 0) ? MODE_HALT : ((k == 1) ? MODE_HOLD : MODE_WAIT);
  endfunction

  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] r;
    b_ok = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(negedge core_clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK("bresp", er, r)
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ar_ok, r_ok;
    logic [1:0] r;
    r_ok = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(negedge core_clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK("rresp", er, r)
  endtask

  // 0 halt, 1 wait, 2 wake
  task automatic cpu_evt(input int k);
    @(posedge core_clk);
    case (k)
      0: halt_exec <= 1'b1;
      1: wait_enter <= 1'b1;
      default: ext_wake <= 1'b1;
    endcase
    @(posedge core_clk);
    {halt_exec, wait_enter, ext_wake} <= 3'b000;
    @(negedge core_clk);
  endtask

  initial begin
    repeat (95000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  initial begin
    logic [31:0] d, got;
    int n;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    `CHK("mode_rst", MODE_RUN, power_mode)
    axi_rd(A_CSR, got, `RESP_OKAY);
    `CHK("csr_rst", 32'h0, got)
    axi_rd(8'h00, got, `RESP_SLVERR);
    axi_wr(8'h04, 32'h1, `RESP_SLVERR);
    repeat (6) begin
      d = $random(seed);
      // the register is always written whole, never through bit operations
      axi_wr(A_CSR, d, `RESP_OKAY);
      axi_rd(A_CSR, got, `RESP_OKAY);
      `CHK("csr_rw", csr_exp(1'b0, d[1], d[3:2]), got)
    end
    // a write without byte lane 0 must leave the register alone
    wstrb <= 4'he;
    axi_wr(A_CSR, 32'hf, `RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(A_CSR, got, `RESP_OKAY);
    `CHK("csr_lane", csr_exp(1'b0, d[1], d[3:2]), got)
    for (int k = 0; k < 3; k++) begin
      axi_wr(A_CSR, (k == 1) ? 32'h2 : 32'h0, `RESP_OKAY);
      cpu_evt((k == 2) ? 1 : 0);
      `CHK("mode_in", mode_exp(k), power_mode)
      axi_wr(A_CSR, 32'hc, `RESP_OKAY);
      axi_rd(A_CSR, got, `RESP_OKAY);
      `CHK("csr_frozen", (k == 2) ? 32'hc : ((k == 1) ? 32'h2 : 32'h0), got)
      cpu_evt(2);
      `CHK("mode_out", MODE_RUN, power_mode)
    end
    axi_wr(A_MASK, 32'h1, `RESP_OKAY);
    axi_wr(A_CSR, 32'h2, `RESP_OKAY);
    osc_on <= 1'b1;
    cpu_evt(1);
    // reselect the longest period halfway; the running period must still end on time
    repeat (30000) @(posedge core_clk);
    axi_wr(A_CSR, 32'he, `RESP_OKAY);
    n = 0;
    while (tick_irq_req !== 1'b1 && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    osc_on <= 1'b0;
    `CHK("tick_edges", 1'b1, osc_edges >= ratio(2'b00) && osc_edges <= ratio(2'b00) + 2)
    @(negedge core_clk);
    `CHK("mode_wake", MODE_RUN, power_mode)
    `CHK("irq_set", 1'b1, irq)
    @(posedge core_clk);
    global_irq_mask <= 1'b1;
    @(negedge core_clk);
    `CHK("req_masked", 1'b0, tick_irq_req)
    @(posedge core_clk);
    global_irq_mask <= 1'b0;
    axi_rd(A_CSR, got, `RESP_OKAY);
    `CHK("csr_tick", csr_exp(1'b1, 1'b1, 2'b11), got)
    @(negedge core_clk);
    `CHK("req_clear", 1'b0, tick_irq_req)
    axi_rd(A_CSR, got, `RESP_OKAY);
    `CHK("csr_clear", csr_exp(1'b0, 1'b1, 2'b11), got)
    axi_rd(A_STAT, got, `RESP_OKAY);
    `CHK("stat_set", 32'h1, got)
    axi_wr(A_MASK, 32'h0, `RESP_OKAY);
    @(negedge core_clk);
    `CHK("irq_masked", 1'b0, irq)
    axi_wr(A_MASK, 32'h1, `RESP_OKAY);
    @(negedge core_clk);
    `CHK("irq_unmasked", 1'b1, irq)
    axi_wr(A_STAT, 32'h1, `RESP_OKAY);
    @(negedge core_clk);
    `CHK("irq_cleared", 1'b0, irq)
    close_out();
  end
endmodule
